/* File: hw/rsf_pkg.sv */
// rsf_pkg: constants, register map and types of the resampler filter
// assumes: byte addressing over an axi4-lite slave, 32-bit data
package rsf_pkg;
   localparam int DATA_W = 24;
   localparam int COEF_W = 12;
   localparam int ACC_W = 44;
   localparam int COEF_DEPTH = 256;
   localparam int BUF_DEPTH = 64;
   localparam int MAX_TAPS = 512;
   localparam int N_CH = 4;
   localparam int RATIO_W = 32;
   localparam int RATIO_INT_LSB = 26;
   localparam int GAIN_LG = 15;
   localparam int MULT_W = 7;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PARTITION = 8'h10;
   localparam logic [7:0] IDX_MULTIPLY = 8'h11;
   localparam logic [7:0] IDX_FILT_SEL = 8'h12;
   localparam logic [7:0] IDX_SHIFT_RND = 8'h13;
   localparam logic [7:0] IDX_RATIO_SYNC = 8'h15;
   localparam logic [7:0] IDX_CLK_DIV = 8'h16;
   localparam logic [7:0] IDX_RATIO_MAP = 8'h17;
   localparam logic [7:0] IDX_COEF_ADDR = 8'h20;
   localparam logic [7:0] IDX_COEF_DATA = 8'h21;
   localparam logic [7:0] IDX_RATIO0 = 8'h24;
   localparam logic [7:0] IDX_STATUS = 8'h28;
   localparam int ADDR_W = 10;
   // field positions
   localparam int FCNT_LSB = 0;
   localparam int CCNT_LSB = 2;
   localparam int NSYM_BIT = 7;
   localparam int SHIFT_LSB = 0;
   localparam int RND_LSB = 4;
   localparam int SHOT_BIT = 2;
   // reset values
   localparam logic [7:0] PARTITION_RST = 8'h08;
   localparam logic [7:0] MULTIPLY_RST = 8'h0f;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [31:0] RATIO_RST = 32'h04000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      RSF_SYNC_NOW = 2'b00,
      RSF_SYNC_PIN = 2'b01,
      RSF_SYNC_SHOT = 2'b10,
      RSF_SYNC_NEVER = 2'b11
   } rsf_sync_e;
   typedef enum logic [1:0] {
      RSF_IDLE = 2'b00,
      RSF_MAC = 2'b01,
      RSF_OUT = 2'b10
   } rsf_state_e;
endpackage

/* File: hw/rsf_resampler.sv */
// rsf_resampler: polyphase resampling filter, register slave and engine
// assumes: samples arrive per channel with valid/ready, output drained by a formatter
`timescale 1ns/1ps
`default_nettype none
module rsf_resampler #(
   parameter int N_CH = rsf_pkg::N_CH
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [rsf_pkg::ADDR_W-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [rsf_pkg::ADDR_W-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic sync_in,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [1:0] in_chan,
   input wire logic [rsf_pkg::DATA_W-1:0] in_i,
   input wire logic [rsf_pkg::DATA_W-1:0] in_q,
   output logic out_valid,
   input wire logic out_ready,
   output logic [1:0] out_chan,
   output logic [rsf_pkg::DATA_W-1:0] out_i,
   output logic [rsf_pkg::DATA_W-1:0] out_q
);
   localparam int DW = rsf_pkg::DATA_W;
   localparam int AW = rsf_pkg::ACC_W;

   logic [7:0] part_q, mult_cfg_q, fsel_q, shrnd_q, rsync_q, div_q, map_q, map_act_q, div_cnt_q, caddr_q;
   logic [31:0] ratio_q [0:3];
   logic [rsf_pkg::COEF_W-1:0] coef_mem [0:rsf_pkg::COEF_DEPTH-1];
   logic [2*DW-1:0] dline [0:rsf_pkg::BUF_DEPTH-1];
   logic [5:0] wp_q [0:N_CH-1];
   logic [31:0] pos_q [0:N_CH-1];
   logic shot_q, bvalid_q, rvalid_q, out_valid_q, tick, wr_fire, rd_fire, in_fire;
   logic [1:0] bresp_q, rresp_q, scan_q, cur_q, out_chan_q;
   logic [31:0] rdata_q;
   logic [DW-1:0] out_i_q, out_q_q;
   logic [7:0] wr_idx, rd_idx;
   logic [1:0] flg, clg;
   logic [6:0] mult, interp, k_q, phase_q;
   logic nsym;
   logic [12:0] tap_count;
   logic signed [AW-1:0] acc_i_q, acc_q_q;
   rsf_pkg::rsf_state_e state_q;

   function automatic logic [6:0] interp_of(input logic [6:0] m, input logic [1:0] lg, input logic ns);
      logic [13:0] budget;
      logic [6:0] res;
      budget = (ns ? 14'd256 : 14'd512) >> lg;
      res = 7'd1;
      for (int s = 0; s <= 6; s++) begin
         if (({7'd0, m} << s) <= budget) begin
            res = 7'(1 << s);
         end
      end
      return res;
   endfunction

   function automatic logic [7:0] coef_addr(input logic [12:0] t, input logic [12:0] n, input logic ns,
                                            input logic [1:0] lg, input logic [1:0] sel);
      logic [12:0] stored;
      stored = t;
      if (!ns && t >= (n >> 1)) begin
         stored = n - 13'd1 - t;
      end
      return 8'((stored << lg) | 13'(sel));
   endfunction

   function automatic logic [DW-1:0] shape(input logic signed [AW-1:0] a, input logic [3:0] sh,
                                           input logic [1:0] rs);
      logic signed [63:0] w;
      logic signed [63:0] lim;
      int drop;
      int wid;
      wid = 12 + 4 * int'(rs);
      drop = rsf_pkg::GAIN_LG + DW - wid;
      w = 64'(a) <<< sh;
      w = (w + (64'sd1 <<< (drop - 1))) >>> drop;
      lim = (64'sd1 <<< (wid - 1)) - 64'sd1;
      if (w > lim) begin
         w = lim;
      end else if (w < -lim - 64'sd1) begin
         w = -lim - 64'sd1;
      end
      return DW'(w <<< (DW - wid));
   endfunction

   // field decode
   assign flg = (part_q[rsf_pkg::FCNT_LSB +: 2] > 2'd1) ? 2'd2 : part_q[rsf_pkg::FCNT_LSB +: 2];
   assign clg = (part_q[rsf_pkg::CCNT_LSB +: 2] > 2'd1) ? 2'd2 : part_q[rsf_pkg::CCNT_LSB +: 2];
   assign mult = mult_cfg_q[rsf_pkg::MULT_W-1:0];
   assign nsym = mult_cfg_q[rsf_pkg::NSYM_BIT];
   assign interp = interp_of(mult, flg, nsym);
   assign tap_count = 13'(mult * interp);

   // axi4-lite slave: address and data taken together
   assign wr_fire = s_awvalid && s_wvalid && !bvalid_q;
   assign s_awready = wr_fire;
   assign s_wready = wr_fire;
   assign rd_fire = s_arvalid && !rvalid_q;
   assign s_arready = !rvalid_q;
   assign wr_idx = s_awaddr[rsf_pkg::ADDR_W-1:2];
   assign rd_idx = s_araddr[rsf_pkg::ADDR_W-1:2];
   assign s_bvalid = bvalid_q;
   assign s_bresp = bresp_q;
   assign s_rvalid = rvalid_q;
   assign s_rresp = rresp_q;
   assign s_rdata = rdata_q;

   function automatic logic mapped(input logic [7:0] i);
      return i inside {rsf_pkg::IDX_PARTITION, rsf_pkg::IDX_MULTIPLY, rsf_pkg::IDX_FILT_SEL,
                       rsf_pkg::IDX_SHIFT_RND, rsf_pkg::IDX_RATIO_SYNC, rsf_pkg::IDX_CLK_DIV,
                       rsf_pkg::IDX_RATIO_MAP, rsf_pkg::IDX_COEF_ADDR, rsf_pkg::IDX_COEF_DATA,
                       rsf_pkg::IDX_STATUS} || (i >= rsf_pkg::IDX_RATIO0 && i < rsf_pkg::IDX_STATUS);
   endfunction

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         bvalid_q <= 1'b0;
         bresp_q <= rsf_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= mapped(wr_idx) ? rsf_pkg::RESP_OKAY : rsf_pkg::RESP_SLVERR;
      end else if (s_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         part_q <= rsf_pkg::PARTITION_RST;
         mult_cfg_q <= rsf_pkg::MULTIPLY_RST;
         fsel_q <= rsf_pkg::BYTE_RST;
         shrnd_q <= rsf_pkg::BYTE_RST;
         rsync_q <= rsf_pkg::BYTE_RST;
         div_q <= rsf_pkg::BYTE_RST;
         map_q <= rsf_pkg::BYTE_RST;
         caddr_q <= rsf_pkg::BYTE_RST;
         shot_q <= 1'b0;
         for (int r = 0; r < 4; r++) begin
            ratio_q[r] <= rsf_pkg::RATIO_RST;
         end
      end else begin
         shot_q <= 1'b0;
         if (wr_fire && s_wstrb[0]) begin
            case (wr_idx)
               rsf_pkg::IDX_PARTITION: part_q <= s_wdata[7:0];
               rsf_pkg::IDX_MULTIPLY: mult_cfg_q <= s_wdata[7:0];
               rsf_pkg::IDX_FILT_SEL: fsel_q <= s_wdata[7:0];
               rsf_pkg::IDX_SHIFT_RND: shrnd_q <= s_wdata[7:0];
               rsf_pkg::IDX_RATIO_SYNC: begin
                  rsync_q <= {s_wdata[7:3], 1'b0, s_wdata[1:0]};
                  shot_q <= s_wdata[rsf_pkg::SHOT_BIT];
               end
               rsf_pkg::IDX_CLK_DIV: div_q <= s_wdata[7:0];
               rsf_pkg::IDX_RATIO_MAP: map_q <= s_wdata[7:0];
               rsf_pkg::IDX_COEF_ADDR: caddr_q <= s_wdata[7:0];
               rsf_pkg::IDX_COEF_DATA: caddr_q <= caddr_q + 8'h01;
               default: ;
            endcase
         end
         for (int r = 0; r < 4; r++) begin
            if (wr_fire && wr_idx == rsf_pkg::IDX_RATIO0 + 8'(r)) begin
               for (int b = 0; b < 4; b++) begin
                  if (s_wstrb[b]) begin
                     ratio_q[r][8*b +: 8] <= s_wdata[8*b +: 8];
                  end
               end
            end
         end
      end
   end

   // coefficient store, h0 at lowest address
   always_ff @(posedge core_clk) begin
      if (wr_fire && s_wstrb[0] && wr_idx == rsf_pkg::IDX_COEF_DATA) begin
         coef_mem[caddr_q] <= s_wdata[rsf_pkg::COEF_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         map_act_q <= rsf_pkg::BYTE_RST;
      end else begin
         case (rsf_pkg::rsf_sync_e'(rsync_q[1:0]))
            rsf_pkg::RSF_SYNC_NOW: map_act_q <= map_q;
            rsf_pkg::RSF_SYNC_PIN: map_act_q <= sync_in ? map_q : map_act_q;
            rsf_pkg::RSF_SYNC_SHOT: map_act_q <= shot_q ? map_q : map_act_q;
            default: map_act_q <= map_act_q;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rvalid_q <= 1'b0;
         rresp_q <= rsf_pkg::RESP_OKAY;
         rdata_q <= 32'h00000000;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rresp_q <= mapped(rd_idx) ? rsf_pkg::RESP_OKAY : rsf_pkg::RESP_SLVERR;
         case (rd_idx)
            rsf_pkg::IDX_PARTITION: rdata_q <= {24'h000000, part_q};
            rsf_pkg::IDX_MULTIPLY: rdata_q <= {24'h000000, mult_cfg_q};
            rsf_pkg::IDX_FILT_SEL: rdata_q <= {24'h000000, fsel_q};
            rsf_pkg::IDX_SHIFT_RND: rdata_q <= {24'h000000, shrnd_q};
            rsf_pkg::IDX_RATIO_SYNC: rdata_q <= {24'h000000, rsync_q};
            rsf_pkg::IDX_CLK_DIV: rdata_q <= {24'h000000, div_q};
            rsf_pkg::IDX_RATIO_MAP: rdata_q <= {24'h000000, map_q};
            rsf_pkg::IDX_COEF_ADDR: rdata_q <= {24'h000000, caddr_q};
            rsf_pkg::IDX_COEF_DATA: rdata_q <= {20'h00000, coef_mem[caddr_q]};
            rsf_pkg::IDX_STATUS: rdata_q <= {8'h00, map_act_q, tap_count, interp[6:0] != 7'h00,
                                             state_q != rsf_pkg::RSF_IDLE, out_valid_q};
            default: rdata_q <= (rd_idx >= rsf_pkg::IDX_RATIO0 && rd_idx < rsf_pkg::IDX_STATUS) ?
                                ratio_q[rd_idx[1:0]] : 32'h00000000;
         endcase
      end else if (s_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // divider: one enable every div_q+1 clocks
   assign tick = (div_cnt_q >= div_q);
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         div_cnt_q <= 8'h00;
      end else begin
         div_cnt_q <= tick ? 8'h00 : div_cnt_q + 8'h01;
      end
   end

   // segmented delay line, one segment per channel
   assign in_fire = in_valid && in_ready;
   assign in_ready = ({1'b0, in_chan} < 3'((N_CH >> 2) << clg))
                     && (pos_q[in_chan][31:rsf_pkg::RATIO_INT_LSB] != 6'h00);
   always_ff @(posedge core_clk) begin
      if (in_fire) begin
         dline[6'((6'(in_chan) << (6 - clg)) | wp_q[in_chan])] <= {in_i, in_q};
      end
   end
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         for (int c = 0; c < N_CH; c++) begin
            wp_q[c] <= 6'h00;
         end
      end else if (in_fire) begin
         wp_q[in_chan] <= (wp_q[in_chan] + 6'h01) & (6'h3f >> clg);
      end
   end

   // engine reads: two taps per enable
   logic [12:0] t0, t1;
   logic [5:0] s0, s1, seg_mask;
   logic signed [rsf_pkg::COEF_W-1:0] c0, c1;
   logic signed [DW-1:0] i0, q0, i1, q1;
   logic use1, last_step;
   assign seg_mask = 6'h3f >> clg;
   assign t0 = 13'(k_q * interp) + 13'(phase_q);
   assign t1 = t0 + 13'(interp);
   assign use1 = (k_q + 7'd1) < mult;
   assign last_step = (k_q + 7'd2) >= mult;
   assign c0 = coef_mem[coef_addr(t0, tap_count, nsym, flg, fsel_q[2*cur_q +: 2])];
   assign c1 = use1 ? coef_mem[coef_addr(t1, tap_count, nsym, flg, fsel_q[2*cur_q +: 2])] : '0;
   assign s0 = (6'(cur_q) << (6 - clg)) | ((wp_q[cur_q] - 6'h01 - 6'(k_q)) & seg_mask);
   assign s1 = (6'(cur_q) << (6 - clg)) | ((wp_q[cur_q] - 6'h02 - 6'(k_q)) & seg_mask);
   assign {i0, q0} = dline[s0];
   assign {i1, q1} = dline[s1];

   // nearest polyphase branch to the fractional position
   logic [32:0] ph_prod;
   logic [6:0] ph_near;
   assign ph_prod = 33'(pos_q[scan_q][rsf_pkg::RATIO_INT_LSB-1:0]) * 33'(interp) + 33'h02000000;
   assign ph_near = (7'(ph_prod[32:rsf_pkg::RATIO_INT_LSB]) >= interp) ? interp - 7'd1
                    : 7'(ph_prod[32:rsf_pkg::RATIO_INT_LSB]);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_q <= rsf_pkg::RSF_IDLE;
         scan_q <= 2'h0;
         cur_q <= 2'h0;
         k_q <= 7'h00;
         phase_q <= 7'h00;
         acc_i_q <= '0;
         acc_q_q <= '0;
         out_valid_q <= 1'b0;
         out_chan_q <= 2'h0;
         out_i_q <= '0;
         out_q_q <= '0;
      end else begin
         case (state_q)
            rsf_pkg::RSF_IDLE: begin
               if (tick) begin
                  if (pos_q[scan_q][31:rsf_pkg::RATIO_INT_LSB] == 6'h00) begin
                     cur_q <= scan_q;
                     phase_q <= ph_near;
                     k_q <= 7'h00;
                     acc_i_q <= '0;
                     acc_q_q <= '0;
                     state_q <= rsf_pkg::RSF_MAC;
                  end else begin
                     scan_q <= (scan_q + 2'h1) & 2'(((N_CH >> 2) << clg) - 1);
                  end
               end
            end
            rsf_pkg::RSF_MAC: begin
               if (tick) begin
                  acc_i_q <= acc_i_q + AW'(i0 * c0) + AW'(i1 * c1);
                  acc_q_q <= acc_q_q + AW'(q0 * c0) + AW'(q1 * c1);
                  k_q <= k_q + 7'd2;
                  if (last_step) begin
                     state_q <= rsf_pkg::RSF_OUT;
                  end
               end
            end
            rsf_pkg::RSF_OUT: begin
               if (!out_valid_q) begin
                  out_i_q <= shape(acc_i_q, shrnd_q[rsf_pkg::SHIFT_LSB +: 4], shrnd_q[rsf_pkg::RND_LSB +: 2]);
                  out_q_q <= shape(acc_q_q, shrnd_q[rsf_pkg::SHIFT_LSB +: 4], shrnd_q[rsf_pkg::RND_LSB +: 2]);
                  out_chan_q <= cur_q;
                  out_valid_q <= 1'b1;
               end else if (out_ready) begin
                  out_valid_q <= 1'b0;
                  scan_q <= (scan_q + 2'h1) & 2'(((N_CH >> 2) << clg) - 1);
                  state_q <= rsf_pkg::RSF_IDLE;
               end
            end
            default: state_q <= rsf_pkg::RSF_IDLE;
         endcase
      end
   end

   // position advances by the mapped ratio
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         for (int c = 0; c < N_CH; c++) begin
            pos_q[c] <= 32'h00000000;
         end
      end else begin
         if (in_fire) begin
            pos_q[in_chan] <= pos_q[in_chan] - (32'h1 << rsf_pkg::RATIO_INT_LSB);
         end
         if (state_q == rsf_pkg::RSF_OUT && out_valid_q && out_ready) begin
            pos_q[cur_q] <= pos_q[cur_q] + ratio_q[map_act_q[2*cur_q +: 2]];
         end
      end
   end

   assign out_valid = out_valid_q;
   assign out_chan = out_chan_q;
   assign out_i = out_i_q;
   assign out_q = out_q_q;

   // checks
   logic [6:0] mac_cyc_q;
   always_ff @(posedge core_clk) begin
      if (!nrst || state_q == rsf_pkg::RSF_IDLE) begin
         mac_cyc_q <= 7'h00;
      end else if (state_q == rsf_pkg::RSF_MAC && tick) begin
         mac_cyc_q <= mac_cyc_q + 7'h01;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_tap_limit: assert property (mult inside {[7'd6:7'd64]} |-> tap_count <= 13'd512)
      else $error("tap count above 512");
   a_interp_pow2: assert property (mult inside {[7'd6:7'd64]} |-> interp inside {7'd4, 7'd8, 7'd16, 7'd32, 7'd64})
      else $error("interpolation factor not 4..64");
   a_mac_length: assert property ($rose(out_valid_q) |-> mac_cyc_q == (mult + 7'd1) >> 1)
      else $error("output before all accumulations");
   a_tick_spacing: assert property (tick && div_q == 8'h02 && $stable(div_q) |=> !tick ##1 !tick ##1 tick)
      else $error("divider spacing wrong");
   a_out_hold: assert property (out_valid_q && !out_ready |=> out_valid_q && $stable(out_i_q) && $stable(out_chan_q))
      else $error("output changed before taken");
   a_round_lsb: assert property (out_valid_q && shrnd_q[5:4] == 2'h0 |-> out_i_q[11:0] == 12'h000)
      else $error("low bits not cleared by rounding");
   a_sync_never: assert property (rsync_q[1:0] == 2'b11 |=> $stable(map_act_q))
      else $error("ratio map changed without sync");
   a_coef_block: assert property (state_q == rsf_pkg::RSF_MAC && mult inside {[7'd6:7'd64]}
      |-> t0 < tap_count && tap_count <= ((13'd512 >> flg) >> nsym))
      else $error("coefficient index outside its block");
   a_input_gate: assert property (in_fire |-> !(state_q != rsf_pkg::RSF_IDLE && in_chan == cur_q))
      else $error("sample written into channel under computation");
   c_output: cover property (out_valid_q && out_ready);
   c_symmetric: cover property (out_valid_q && !nsym && out_ready);
   c_map_shot: cover property (shot_q && map_q != map_act_q);
   c_unmapped: cover property (rd_fire && !mapped(rd_idx));
endmodule
`default_nettype wire

/* File: sim/rsf_stream_partner.sv */
// rsf_stream_partner: upstream sample source and downstream drain for the resampler
// assumes: bench raises req with a sample and waits for taken; one channel only
`timescale 1ns/1ps
`default_nettype none
module rsf_stream_partner #(
   parameter bit SLOW = 1'b1
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic req,
   input wire logic [23:0] req_i,
   output logic taken,
   output logic in_valid,
   input wire logic in_ready,
   output logic [1:0] in_chan,
   output logic [23:0] in_i,
   output logic [23:0] in_q,
   input wire logic out_valid,
   output logic out_ready
);
   assign in_chan = 2'h0;
   always_ff @(posedge core_clk) begin
      taken <= in_valid & in_ready & nrst;
      if (!nrst) begin
         in_valid <= 1'b0;
         in_i <= 24'h000000;
         in_q <= 24'h000000;
      end else if (in_valid && in_ready) begin
         in_valid <= 1'b0;
         in_i <= ~in_i;
         in_q <= ~in_q;
      end else if (req && !taken && !in_valid) begin
         in_valid <= 1'b1;
         in_i <= req_i;
         in_q <= req_i;
      end
   end
   // drain stalls one cycle per output when slow
   always_ff @(posedge core_clk) begin
      out_ready <= nrst & (SLOW ? (out_valid & ~out_ready) : 1'b1);
   end
endmodule
`default_nettype wire

/* File: sim/polyphase_resampler_filter_tb.sv */
// polyphase_resampler_filter_tb: register and data checks of the resampler
// assumes: rsf_resampler with axi4-lite slave, partner model on the streams
`timescale 1ns/1ps
`default_nettype none
module polyphase_resampler_filter_tb;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [9:0] awaddr = '0;
   logic [9:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic [31:0] v;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, sync_in = 1'b0, req = 1'b0;
   logic [23:0] ri = '0;
   logic s_awready, s_wready, bvalid, arready, rvalid, in_valid, in_ready, out_valid, out_ready, taken;
   logic [1:0] bresp, rresp, in_chan, out_chan;
   logic [31:0] rdata;
   logic [23:0] in_i, in_q, out_i, out_q;
   int err_total = 0;
   int n_compared = 0;
   logic [7:0] sr [5] = '{8'h35, 8'h05, 8'h36, 8'h3f, 8'h3f};
   logic [23:0] smp [5] = '{24'h123456, 24'h123856, 24'h100000, 24'h010000, 24'hff0000};
   logic [23:0] ex [5] = '{24'h123456, 24'h124000, 24'h200000, 24'h7fffff, 24'h800000};
   always #10 core_clk = ~core_clk;
   rsf_resampler rsf_resampler_inst (.core_clk(core_clk), .nrst(nrst), .s_awaddr(awaddr), .s_awvalid(awv),
      .s_awready(s_awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wv), .s_wready(s_wready),
      .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arv),
      .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
      .sync_in(sync_in), .in_valid(in_valid), .in_ready(in_ready), .in_chan(in_chan), .in_i(in_i),
      .in_q(in_q), .out_valid(out_valid), .out_ready(out_ready), .out_chan(out_chan), .out_i(out_i),
      .out_q(out_q));
   rsf_stream_partner rsf_stream_partner_inst (.core_clk(core_clk), .nrst(nrst), .req(req), .req_i(ri),
      .taken(taken), .in_valid(in_valid), .in_ready(in_ready), .in_chan(in_chan), .in_i(in_i),
      .in_q(in_q), .out_valid(out_valid), .out_ready(out_ready));
   task automatic print_verdict();
      if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask
   function automatic logic [9:0] ba(input logic [7:0] i);
      return {i, 2'b00};
   endfunction
   task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do @(posedge core_clk); while (s_awready !== 1'b1);
      awv <= 1'b0;
      wv <= 1'b0;
      bready <= 1'b1;
      do @(posedge core_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", 32'(er), 32'(bresp));
   endtask
   task automatic rd(input logic [9:0] a, output logic [31:0] d, input logic [1:0] er);
      araddr <= a;
      arv <= 1'b1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arv <= 1'b0;
      rready <= 1'b1;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      chk("rresp", 32'(er), 32'(rresp));
   endtask
   task automatic feed(input logic [23:0] s);
      req <= 1'b1;
      ri <= s;
      do @(posedge core_clk); while (taken !== 1'b1);
      req <= 1'b0;
      do @(posedge core_clk); while (!(out_valid === 1'b1 && out_ready === 1'b1));
   endtask
   task automatic map_chk(input logic [7:0] e);
      rd(ba(rsf_pkg::IDX_STATUS), v, rsf_pkg::RESP_OKAY);
      chk("active map", 32'(e), 32'(v[23:16]));
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      // let the start-up outputs of all four channels drain before reconfiguring
      repeat (100) @(posedge core_clk);
      rd(ba(rsf_pkg::IDX_PARTITION), v, rsf_pkg::RESP_OKAY);
      chk("partition", 32'h08, v);
      rd(ba(rsf_pkg::IDX_MULTIPLY), v, rsf_pkg::RESP_OKAY);
      chk("multiply", 32'h0f, v);
      rd(ba(rsf_pkg::IDX_RATIO0), v, rsf_pkg::RESP_OKAY);
      chk("ratio0", 32'h04000000, v);
      rd(10'h3fc, v, rsf_pkg::RESP_SLVERR);
      chk("unmapped", 32'h0, v);
      wr(10'h3fc, 32'h1, rsf_pkg::RESP_SLVERR);
      wr(ba(rsf_pkg::IDX_CLK_DIV), 32'h02, rsf_pkg::RESP_OKAY);
      rd(ba(rsf_pkg::IDX_CLK_DIV), v, rsf_pkg::RESP_OKAY);
      chk("clock divider", 32'h02, v);
      wr(ba(rsf_pkg::IDX_SHIFT_RND), 32'h135, rsf_pkg::RESP_OKAY);
      rd(ba(rsf_pkg::IDX_SHIFT_RND), v, rsf_pkg::RESP_OKAY);
      chk("shift round", 32'h35, v);
      // bypass setup: one channel, count 7, non-symmetric, h0 only
      wr(ba(rsf_pkg::IDX_PARTITION), 32'h00, rsf_pkg::RESP_OKAY);
      wr(ba(rsf_pkg::IDX_MULTIPLY), 32'h87, rsf_pkg::RESP_OKAY);
      wr(ba(rsf_pkg::IDX_COEF_ADDR), 32'h0, rsf_pkg::RESP_OKAY);
      wr(ba(rsf_pkg::IDX_COEF_DATA), 32'h400, rsf_pkg::RESP_OKAY);
      for (int k = 1; k < 256; k++) wr(ba(rsf_pkg::IDX_COEF_DATA), 32'h0, rsf_pkg::RESP_OKAY);
      wr(ba(rsf_pkg::IDX_COEF_ADDR), 32'h0, rsf_pkg::RESP_OKAY);
      rd(ba(rsf_pkg::IDX_COEF_DATA), v, rsf_pkg::RESP_OKAY);
      chk("coef zero", 32'h400, v);
      rd(ba(rsf_pkg::IDX_STATUS), v, rsf_pkg::RESP_OKAY);
      chk("tap count", 32'd224, 32'(v[15:3]));
      for (int k = 0; k < 64; k++) feed(24'h000000);
      for (int k = 0; k < 5; k++) begin
         wr(ba(rsf_pkg::IDX_SHIFT_RND), 32'(sr[k]), rsf_pkg::RESP_OKAY);
         feed(smp[k]);
         chk("out i", 32'(ex[k]), 32'(out_i));
         chk("out q", 32'(ex[k]), 32'(out_q));
         chk("out chan", 32'h0, 32'(out_chan));
      end
      wr(ba(rsf_pkg::IDX_RATIO_SYNC), 32'h3, rsf_pkg::RESP_OKAY);
      wr(ba(rsf_pkg::IDX_RATIO_MAP), 32'h1, rsf_pkg::RESP_OKAY);
      map_chk(8'h00);
      wr(ba(rsf_pkg::IDX_RATIO_SYNC), 32'h1, rsf_pkg::RESP_OKAY);
      map_chk(8'h00);
      sync_in <= 1'b1;
      @(posedge core_clk);
      sync_in <= 1'b0;
      map_chk(8'h01);
      wr(ba(rsf_pkg::IDX_RATIO_MAP), 32'h2, rsf_pkg::RESP_OKAY);
      wr(ba(rsf_pkg::IDX_RATIO_SYNC), 32'h6, rsf_pkg::RESP_OKAY);
      map_chk(8'h02);
      wr(ba(rsf_pkg::IDX_RATIO_SYNC), 32'h0, rsf_pkg::RESP_OKAY);
      wr(ba(rsf_pkg::IDX_RATIO_MAP), 32'h3, rsf_pkg::RESP_OKAY);
      map_chk(8'h03);
      print_verdict();
   end
endmodule
`default_nettype wire
